// *** rop_pkg.sv ***
// constants, field layout and register map of the relay output pack control
// assumes a 10 MHz mclk and an APB master with 32-bit data

package rop_pkg;
  localparam int CLK_KHZ = 10000; // mclk rate in kHz
  localparam int NCH = 12;
  localparam int NMON = 15;
  localparam int NFUSE = 6;
  localparam int NSOL = 6;
  localparam int NDIAG = 19;
  localparam int ADDR_W = 8;
  localparam int FILT_W = 20;

  // select settle time, then derived cycle count
  localparam int MUX_SETTLE_US = 20;
  localparam int MUX_SETTLE_CYC = (MUX_SETTLE_US * CLK_KHZ + 999) / 1000;
  localparam int CMD_LATENCY_MS = 6; // bound met with two cycles of latency (relayCmd_r, then relayDrive)

  // feedback filter times in ms
  localparam int FILT_MS_TEN = 10;
  localparam int FILT_MS_TWENTY = 20;
  localparam int FILT_MS_FIFTY = 50;
  localparam int FILT_MS_HUNDRED = 100;
  localparam logic [2:0] FSEL_ZERO = 3'h0;
  localparam logic [2:0] FSEL_TEN = 3'h1;
  localparam logic [2:0] FSEL_TWENTY = 3'h2;
  localparam logic [2:0] FSEL_FIFTY = 3'h3;
  localparam logic [2:0] FSEL_HUNDRED = 3'h4;

  // offline policy encoding
  localparam logic [1:0] POL_DEENERGIZE = 2'h0;
  localparam logic [1:0] POL_FREEZE = 2'h1;
  localparam logic [1:0] POL_PRESET = 2'h2;

  // register byte offsets
  localparam logic [7:0] REG_CHAN_EN = 8'h00;
  localparam logic [7:0] REG_OUT_INV = 8'h04;
  localparam logic [7:0] REG_POL_INV = 8'h08;
  localparam logic [7:0] REG_FB_EN = 8'h0c;
  localparam logic [7:0] REG_EVT_FB = 8'h10;
  localparam logic [7:0] REG_EVT_CMD = 8'h14;
  localparam logic [7:0] REG_CFG = 8'h18;
  localparam logic [7:0] REG_PRESET = 8'h1c;
  localparam logic [7:0] REG_LATCH_EN = 8'h20;
  localparam logic [7:0] REG_DIAG_RST = 8'h24;
  localparam logic [7:0] REG_DRV_FB = 8'h28;
  localparam logic [7:0] REG_CONTACT = 8'h2c;
  localparam logic [7:0] REG_DIAG = 8'h30;
  localparam logic [7:0] REG_MISC = 8'h34;
  localparam logic [7:0] REG_CMD = 8'h38;

  // config field positions
  localparam int CFG_POL_LSB = 0;
  localparam int CFG_FILT_LSB = 2;
  localparam int CFG_FUSE_BIT = 5;
  localparam int CFG_VOTE_BIT = 6;
  localparam int CFG_W = 7;

  // diagnostic field positions
  localparam int DG_MIS_LSB = 0;
  localparam int DG_FUSE_LSB = 12;
  localparam int DG_VOTE_BIT = 18;

  // monitor set layout
  localparam int MON_FUSE_LSB = 12;

  // misc status field positions
  localparam int MS_FUSE_LSB = 0;
  localparam int MS_SOL_LSB = 6;
  localparam int MS_LINK_BIT = 12;
  localparam int MS_OEN_BIT = 13;

  // reset values
  localparam logic [11:0] CH_RST = 12'h000;
  localparam logic [CFG_W-1:0] CFG_RST = 7'h00;
  localparam logic [NDIAG-1:0] LATCH_RST = 19'h7ffff;
endpackage : rop_pkg

// *** rop_relay_ctrl.sv ***
// relay output pack control: command path, monitor mux, diagnostics, events
// assumes all inputs synchronous to mclk; APB slave with one-cycle access
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps

module rop_relay_ctrl import rop_pkg::*; #(
  parameter int FILT10_CYC = FILT_MS_TEN * CLK_KHZ,
  parameter int FILT20_CYC = FILT_MS_TWENTY * CLK_KHZ,
  parameter int FILT50_CYC = FILT_MS_FIFTY * CLK_KHZ,
  parameter int FILT100_CYC = FILT_MS_HUNDRED * CLK_KHZ
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic primaryNetLinkUp,
  input wire logic primaryNetValid,
  input wire logic [NCH-1:0] primaryNetCmd,
  input wire logic secondaryNetLinkUp,
  input wire logic secondaryNetValid,
  input wire logic [NCH-1:0] secondaryNetCmd,
  input wire logic diagResetRequest,
  input wire logic selfTestDone,
  input wire logic powerGood,
  input wire logic boardFuseSense,
  input wire logic boardFilterCapable,
  input wire logic boardSolenoidSense,
  input wire logic voteDisagree,
  input wire logic [NMON-1:0] monitorN,
  output logic muxSelN,
  output logic outputEnable,
  output logic [NCH-1:0] relayDrive,
  output logic [NCH-1:0] chanLed,
  output logic linkGoodFlag,
  output logic attentionFlag,
  output logic packDiagFlag,
  output logic eventValid,
  output logic [31:0] eventStamp,
  output logic [NCH-1:0] eventFbMask,
  output logic [NCH-1:0] eventFbValue,
  output logic [NCH-1:0] eventCmdMask,
  output logic [NCH-1:0] eventCmdValue
);

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  logic [NCH-1:0] chanEn_r, outInv_r, polInv_r, fbEn_r, evtFbEn_r;
  logic [NCH-1:0] evtCmdEn_r, preset_r;
  logic [CFG_W-1:0] cfg_r;
  logic [NDIAG-1:0] latchEn_r, diag_r, diagCond;
  logic [31:0] rd_nxt;
  logic err_nxt;
  logic apbWr;
  logic [NCH-1:0] relayCmd_r, drvFbRep, contactRep;
  logic [NFUSE-1:0] fuseOk;
  logic [NSOL-1:0] solOk;
  logic linkUp;

  // write takes effect at the edge that samples pready high
  assign apbWr = psel & penable & pready & pwrite & ~pslverr;

  // read data and error are prepared during the setup cycle
  always_comb begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    unique case (paddr)
      REG_CHAN_EN: rd_nxt[NCH-1:0] = chanEn_r;
      REG_OUT_INV: rd_nxt[NCH-1:0] = outInv_r;
      REG_POL_INV: rd_nxt[NCH-1:0] = polInv_r;
      REG_FB_EN: rd_nxt[NCH-1:0] = fbEn_r;
      REG_EVT_FB: rd_nxt[NCH-1:0] = evtFbEn_r;
      REG_EVT_CMD: rd_nxt[NCH-1:0] = evtCmdEn_r;
      REG_CFG: rd_nxt[CFG_W-1:0] = cfg_r;
      REG_PRESET: rd_nxt[NCH-1:0] = preset_r;
      REG_LATCH_EN: rd_nxt[NDIAG-1:0] = latchEn_r;
      REG_DIAG_RST: rd_nxt = 32'h0000_0000;
      REG_DRV_FB: rd_nxt[NCH-1:0] = drvFbRep;
      REG_CONTACT: rd_nxt[NCH-1:0] = contactRep;
      REG_DIAG: rd_nxt[NDIAG-1:0] = diag_r;
      REG_MISC: begin
        rd_nxt[MS_FUSE_LSB +: NFUSE] = fuseOk;
        rd_nxt[MS_SOL_LSB +: NSOL] = solOk;
        rd_nxt[MS_LINK_BIT] = linkUp;
        rd_nxt[MS_OEN_BIT] = outputEnable;
      end
      REG_CMD: rd_nxt[NCH-1:0] = relayCmd_r;
      default: err_nxt = 1'b1; // unmapped address
    endcase
  end

  // one wait-free access phase: pready rises the cycle after setup
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= err_nxt;
      prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      chanEn_r <= CH_RST;
      outInv_r <= CH_RST;
      polInv_r <= CH_RST;
      fbEn_r <= CH_RST;
      evtFbEn_r <= CH_RST;
      evtCmdEn_r <= CH_RST;
      preset_r <= CH_RST;
      cfg_r <= CFG_RST;
      latchEn_r <= LATCH_RST;
    end else if (apbWr) begin
      unique case (paddr)
        REG_CHAN_EN: chanEn_r <= pwdata[NCH-1:0];
        REG_OUT_INV: outInv_r <= pwdata[NCH-1:0];
        REG_POL_INV: polInv_r <= pwdata[NCH-1:0];
        REG_FB_EN: fbEn_r <= pwdata[NCH-1:0];
        REG_EVT_FB: evtFbEn_r <= pwdata[NCH-1:0];
        REG_EVT_CMD: evtCmdEn_r <= pwdata[NCH-1:0];
        REG_CFG: cfg_r <= pwdata[CFG_W-1:0];
        REG_PRESET: preset_r <= pwdata[NCH-1:0];
        REG_LATCH_EN: latchEn_r <= pwdata[NDIAG-1:0];
        default: ; // read-only and request registers
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command path

  logic [1:0] policy;
  logic [NCH-1:0] effCmd, drive_nxt;

  assign policy = cfg_r[CFG_POL_LSB +: 2];
  assign linkUp = primaryNetLinkUp | secondaryNetLinkUp;

  // either port carries commands; primary wins a same-cycle tie
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      relayCmd_r <= CH_RST;
    end else if (primaryNetValid && primaryNetLinkUp) begin
      relayCmd_r <= primaryNetCmd;
    end else if (secondaryNetValid && secondaryNetLinkUp) begin
      relayCmd_r <= secondaryNetCmd;
    end
  end

  // offline policy picks the command; unknown codes act as de-energize
  always_comb begin
    effCmd = relayCmd_r;
    drive_nxt = CH_RST;
    if (!linkUp && policy == POL_PRESET) begin
      effCmd = preset_r;
    end
    if (linkUp || policy == POL_FREEZE || policy == POL_PRESET) begin
      drive_nxt = chanEn_r & (effCmd ^ outInv_r);
    end
  end

  // enable line is the only gate needed to keep relays dropped out
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      outputEnable <= 1'b0;
      relayDrive <= CH_RST;
    end else begin
      outputEnable <= selfTestDone & powerGood;
      relayDrive <= outputEnable ? drive_nxt : CH_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitor multiplexing

  logic [15:0] settleCnt_r;
  logic [NMON-1:0] setA_r, setB_r, mon;
  logic latchA;

  assign mon = ~monitorN;
  assign latchA = settleCnt_r == 16'(MUX_SETTLE_CYC - 1) && muxSelN;

  // hold each select state until the board settles, then flip it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      settleCnt_r <= 16'h0000;
      muxSelN <= 1'b1;
      setA_r <= '0;
      setB_r <= '0;
    end else if (settleCnt_r == 16'(MUX_SETTLE_CYC - 1)) begin
      settleCnt_r <= 16'h0000;
      muxSelN <= ~muxSelN;
      if (muxSelN) begin
        setA_r <= mon;
      end else begin
        setB_r <= mon;
      end
    end else begin
      settleCnt_r <= settleCnt_r + 16'h0001;
    end
  end

  // both select states each carry three fuse lines
  assign fuseOk = {setB_r[MON_FUSE_LSB +: 3], setA_r[MON_FUSE_LSB +: 3]};
  assign solOk = boardSolenoidSense ? setB_r[NSOL-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////////
  // feedback filter

  logic [FILT_W-1:0] filtLimit;
  logic [NCH-1:0] fbFilt_r, fbSettled;

  // filter is only offered where the board supports it
  always_comb begin
    filtLimit = '0;
    if (boardFilterCapable) begin
      unique case (cfg_r[CFG_FILT_LSB +: 3])
        FSEL_TEN: filtLimit = FILT_W'(FILT10_CYC);
        FSEL_TWENTY: filtLimit = FILT_W'(FILT20_CYC);
        FSEL_FIFTY: filtLimit = FILT_W'(FILT50_CYC);
        FSEL_HUNDRED: filtLimit = FILT_W'(FILT100_CYC);
        default: filtLimit = '0; // zero and illegal codes
      endcase
    end
  end

  // per channel: a new level must persist for the whole filter time
  for (genvar ch = 0; ch < NCH; ch++) begin : g_filt
    logic [FILT_W-1:0] cnt_r;
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        cnt_r <= '0;
        fbFilt_r[ch] <= 1'b0;
      end else if (setA_r[ch] == fbFilt_r[ch]) begin
        cnt_r <= '0;
      end else if (cnt_r >= filtLimit) begin
        fbFilt_r[ch] <= setA_r[ch];
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
    assign fbSettled[ch] = setA_r[ch] == fbFilt_r[ch];
  end

  assign drvFbRep = fbEn_r & (fbFilt_r ^ polInv_r);
  assign contactRep = fbEn_r & (setB_r[NCH-1:0] ^ polInv_r);

  // indicator needs a command and, with feedback in use, a sensed load
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      chanLed <= CH_RST;
    end else begin
      chanLed <= relayDrive & (setA_r[NCH-1:0] | ~fbEn_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // diagnostics

  logic [NCH-1:0] drvPrev1_r, drvPrev2_r, stable;
  logic rstReq;

  // drive history sampled with set A so transients are not flagged
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drvPrev1_r <= CH_RST;
      drvPrev2_r <= CH_RST;
    end else if (latchA) begin
      drvPrev1_r <= relayDrive;
      drvPrev2_r <= drvPrev1_r;
    end
  end

  assign stable = ~(relayDrive ^ drvPrev1_r) & ~(drvPrev1_r ^ drvPrev2_r);
  assign diagCond[DG_MIS_LSB +: NCH] =
    chanEn_r & fbEn_r & stable & fbSettled & (fbFilt_r ^ relayDrive);
  assign diagCond[DG_FUSE_LSB +: NFUSE] =
    (cfg_r[CFG_FUSE_BIT] && boardFuseSense) ? ~fuseOk : '0;
  assign diagCond[DG_VOTE_BIT] = cfg_r[CFG_VOTE_BIT] & voteDisagree;
  assign rstReq = diagResetRequest | (apbWr && paddr == REG_DIAG_RST);

  // a live condition always wins, so only healthy latches clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      diag_r <= '0;
    end else begin
      diag_r <= diagCond | (diag_r & latchEn_r & ~{NDIAG{rstReq}});
    end
  end

  // pack-level flags for the controller
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      linkGoodFlag <= 1'b0;
      attentionFlag <= 1'b1;
      packDiagFlag <= 1'b0;
    end else begin
      linkGoodFlag <= linkUp;
      attentionFlag <= ~outputEnable | ~linkUp;
      packDiagFlag <= |diag_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event records

  logic [31:0] stamp_r;
  logic [NCH-1:0] fbPrev_r, cmdPrev_r, fbChg, cmdChg;

  // all channels changing in one cycle share one record
  assign fbChg = (drvFbRep ^ fbPrev_r) & evtFbEn_r;
  assign cmdChg = (relayCmd_r ^ cmdPrev_r) & evtCmdEn_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stamp_r <= 32'h0000_0000;
      fbPrev_r <= CH_RST;
      cmdPrev_r <= CH_RST;
      eventValid <= 1'b0;
      eventStamp <= 32'h0000_0000;
      eventFbMask <= CH_RST;
      eventFbValue <= CH_RST;
      eventCmdMask <= CH_RST;
      eventCmdValue <= CH_RST;
    end else begin
      stamp_r <= stamp_r + 32'h0000_0001; // wraps after about 7 minutes
      fbPrev_r <= drvFbRep;
      cmdPrev_r <= relayCmd_r;
      eventValid <= |{fbChg, cmdChg};
      eventStamp <= stamp_r;
      eventFbMask <= fbChg;
      eventFbValue <= drvFbRep;
      eventCmdMask <= cmdChg;
      eventCmdValue <= relayCmd_r;
    end
  end

endmodule : rop_relay_ctrl

// *** rop_relay_ctrl_asserts.sv ***
// checker on the ports of the relay output pack control
// assumes a bind to rop_relay_ctrl, one clock mclk and reset nrst
`timescale 1ns/1ps

module rop_relay_ctrl_asserts import rop_pkg::*; (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic selfTestDone,
  input wire logic powerGood,
  input wire logic primaryNetLinkUp,
  input wire logic secondaryNetLinkUp,
  input wire logic muxSelN,
  input wire logic outputEnable,
  input wire logic [NCH-1:0] relayDrive,
  input wire logic [NCH-1:0] chanLed,
  input wire logic linkGoodFlag,
  input wire logic attentionFlag,
  input wire logic eventValid,
  input wire logic [31:0] eventStamp
);
  // one domain, so clock and reset are named once
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // gating: $past(nrst) skips the edge that still sees reset values
  chk_oen_gate: assert property (
    $past(nrst) |-> outputEnable == $past(selfTestDone && powerGood))
    else $error("enable not from self-test and power");
  chk_drive_off: assert property (
    !outputEnable |=> relayDrive == '0)
    else $error("relay driven while disabled");
  chk_led_cmd: assert property (
    (chanLed & ~(relayDrive | $past(relayDrive))) == '0)
    else $error("indicator lit without command");
  // select line: settle time per state
  chk_mux_period: assert property (
    $changed(muxSelN) |-> ##[195:205] $changed(muxSelN))
    else $error("select period out of range");
  chk_mux_hold: assert property (
    $changed(muxSelN) |=> $stable(muxSelN) [*8])
    else $error("select changed before settling");
  // flags toward the controller
  chk_link_good: assert property (
    (primaryNetLinkUp || secondaryNetLinkUp) [*3] |-> linkGoodFlag)
    else $error("link flag low with a port up");
  chk_link_lost: assert property (
    !(primaryNetLinkUp || secondaryNetLinkUp) [*3] |-> !linkGoodFlag)
    else $error("link flag high with both ports down");
  chk_attn_flag: assert property (
    !outputEnable |=> attentionFlag)
    else $error("attention low while disabled");
  chk_evt_stamp: assert property (
    eventValid && $past(eventValid) |->
      eventStamp == $past(eventStamp) + 32'h1)
    else $error("stamps of adjacent records not one apart");
  chk_apb_ready: assert property (
    psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_apb_err: assert property (
    pslverr |-> pready)
    else $error("error flag outside answer");
  cover property (eventValid && $past(eventValid));
  cover property (pslverr);
  cover property ($fell(muxSelN));
endmodule : rop_relay_ctrl_asserts

//////////////////////////////////////////////////////////////////////
bind rop_relay_ctrl rop_relay_ctrl_asserts rop_relay_ctrl_asserts_inst (
  .mclk, .nrst, .psel, .penable, .pready, .pslverr, .selfTestDone,
  .powerGood, .primaryNetLinkUp, .secondaryNetLinkUp, .muxSelN,
  .outputEnable, .relayDrive, .chanLed, .linkGoodFlag, .attentionFlag,
  .eventValid, .eventStamp);

// *** rop_net_model.sv ***
// plant controller model on the two redundant network ports
// assumes its tasks are called just after a rising mclk edge
`timescale 1ns/1ps

module rop_net_model import rop_pkg::*; (
  input wire logic mclk,
  output logic pLink,
  output logic pValid,
  output logic [NCH-1:0] pCmd,
  output logic sLink,
  output logic sValid,
  output logic [NCH-1:0] sCmd
);
  // both ports connected and quiet from time zero
  initial begin
    {pLink, sLink, pValid, sValid} = 4'h3 << 2;
    pCmd = '0;
    sCmd = '0;
  end

  // word held across the edge that takes it; valid is left high
  task automatic send(input logic port, input logic [NCH-1:0] cmd);
    pValid <= !port;
    sValid <= port;
    if (port)
      sCmd <= cmd;
    else
      pCmd <= cmd;
    @(posedge mclk);
  endtask : send

  // released word lines on both ports show the inverse of what they held
  task automatic idle;
    pValid <= 1'b0;
    sValid <= 1'b0;
    pCmd <= ~pCmd;
    sCmd <= ~sCmd;
  endtask : idle

  task automatic links(input logic p, input logic s);
    pLink <= p;
    sLink <= s;
  endtask : links
endmodule : rop_net_model

// *** testbench.sv ***
// self-checking bench for the relay output pack control
// assumes rop_pkg, the bound checker and the network model
`timescale 1ns/1ps

module testbench import rop_pkg::*;;
  logic mclk = 1'b0;
  logic nrst, psel, penable, pwrite, selfTestDone, powerGood;
  logic pready, pslverr, muxSelN, outputEnable, eventValid;
  logic pLink, sLink, pValid, sValid, pDiag;
  logic voteDis = 1'b0, diagReq = 1'b0, solSense = 1'b0;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, eventStamp;
  logic [NCH-1:0] pCmd, sCmd, relayDrive, eCm, eCv, cmd, en, inv, ex;
  logic [NMON-1:0] monitorN;
  logic [64:0] rdQ[$], q;
  logic [23:0] evQ[$], e;
  int nErrors = 0, nTests = 0, cycles = 0, seed = 73191;

  // 10 MHz clock
  always #50 mclk = ~mclk;

  // short filter counts keep any filtered run brief
  rop_relay_ctrl #(.FILT10_CYC(4), .FILT20_CYC(8), .FILT50_CYC(16),
    .FILT100_CYC(32)) rop_relay_ctrl_inst (.mclk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .primaryNetLinkUp(pLink), .primaryNetValid(pValid),
    .primaryNetCmd(pCmd), .secondaryNetLinkUp(sLink),
    .secondaryNetValid(sValid), .secondaryNetCmd(sCmd),
    .diagResetRequest(diagReq), .selfTestDone, .powerGood,
    .boardFuseSense(1'b1), .boardFilterCapable(1'b1),
    .boardSolenoidSense(solSense), .voteDisagree(voteDis), .monitorN,
    .muxSelN, .outputEnable, .relayDrive, .chanLed(), .linkGoodFlag(),
    .attentionFlag(), .packDiagFlag(pDiag), .eventValid, .eventStamp,
    .eventFbMask(), .eventFbValue(), .eventCmdMask(eCm),
    .eventCmdValue(eCv));
  rop_net_model rop_net_model_inst (.mclk, .pLink, .pValid, .pCmd, .sLink,
    .sValid, .sCmd);

  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, want, input string what);
    nTests++;
    if (got !== want) begin
      nErrors++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, want);
    end
  endtask : check

  task automatic closeOut;
    $display("checks %0d mismatches %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : closeOut

  // one transfer, held until pready is seen at an edge, then an idle edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] want,
    input logic [31:0] m = 32'hffffffff, input logic err = 1'b0);
    rdQ.push_back({err, m, want & m});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic waitDrive(input logic [NCH-1:0] want, input int lim);
    for (int i = 0; i < lim && relayDrive !== want; i++) @(posedge mclk);
    check(relayDrive, want, "drive");
  endtask : waitDrive

  // oldest note against what appears; the hang limit comes last
  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite) begin
      q = rdQ.pop_front();
      check(prdata & q[63:32], q[31:0], "read");
      check(pslverr, q[64], "error");
    end
    if (eventValid) begin
      e = evQ.pop_front();
      check(eCm, e[23:12], "record mask");
      check(eCv & eCm, e[11:0] & e[23:12], "record value");
    end
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      closeOut();
    end
  end

  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, selfTestDone, powerGood} = '0;
    paddr = '0;
    pwdata = '0;
    monitorN = '1;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rd(REG_LATCH_EN, 32'h7ffff);
    rd(REG_CFG, 32'h0);
    rd(8'h3c, 32'h0, 32'hffffffff, 1'b1);
    // outputs off until power and self-test are both good
    apb(1'b1, REG_CHAN_EN, 32'hfff);
    powerGood <= 1'b1;
    rop_net_model_inst.send(1'b0, 12'hfff);
    rop_net_model_inst.idle();
    repeat (4) @(posedge mclk);
    waitDrive(12'h000, 0);
    selfTestDone <= 1'b1;
    repeat (2) @(posedge mclk);
    rop_net_model_inst.send(1'b0, 12'hfff);
    rop_net_model_inst.idle();
    waitDrive(12'hfff, 2);
    // random words on alternate ports with enables and inversion
    for (int k = 0; k < 8; k++) begin
      {en, inv, cmd} = {12'($random(seed)), 24'($random(seed))};
      monitorN <= 15'($random(seed));
      apb(1'b1, REG_CHAN_EN, {20'h0, en});
      apb(1'b1, REG_OUT_INV, {20'h0, inv});
      rop_net_model_inst.send(k[0], cmd);
      rop_net_model_inst.idle();
      waitDrive(en & (cmd ^ inv), 2);
    end
    // a word on a port whose link is down is refused
    apb(1'b1, REG_CHAN_EN, 32'hfff);
    apb(1'b1, REG_OUT_INV, 32'h0);
    rop_net_model_inst.links(1'b0, 1'b1);
    rop_net_model_inst.send(1'b1, 12'h3c5);
    rop_net_model_inst.send(1'b0, 12'hc3a);
    rop_net_model_inst.idle();
    rd(REG_CMD, 32'h3c5);
    waitDrive(12'h3c5, 0);
    rop_net_model_inst.links(1'b1, 1'b1);
    // back-to-back words each leave one record
    apb(1'b1, REG_EVT_CMD, 32'hfff);
    evQ.push_back({12'hfff, 12'hc3a});
    evQ.push_back({12'h001, 12'hc3b});
    rop_net_model_inst.send(1'b0, 12'hc3a);
    rop_net_model_inst.send(1'b0, 12'hc3b);
    rop_net_model_inst.idle();
    apb(1'b1, REG_EVT_CMD, 32'h0);
    // link loss under each policy code, the spare one included
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, REG_CFG, 32'(p));
      apb(1'b1, REG_PRESET, 32'h5a3);
      rop_net_model_inst.links(1'b0, 1'b0);
      ex = (p == 1) ? 12'hc3b : (p == 2) ? 12'h5a3 : 12'h000;
      waitDrive(ex, 8);
      rop_net_model_inst.links(1'b1, 1'b1);
      rop_net_model_inst.send(1'b0, 12'hc3b);
      rop_net_model_inst.idle();
      waitDrive(12'hc3b, 2);
    end
    // both sets latched through the select line, then polarity flipped
    monitorN <= ~15'h5a5c;
    apb(1'b1, REG_FB_EN, 32'hfff);
    for (int s = 0; s < 2; s++) begin
      repeat (450) @(posedge mclk);
      ex = s ? 12'h5a3 : 12'ha5c;
      rd(REG_DRV_FB, {20'h0, ex});
      rd(REG_CONTACT, {20'h0, ex});
      rd(REG_MISC, 32'h2d, 32'h3f);
      apb(1'b1, REG_POL_INV, 32'hfff);
    end
    // solenoid flags come from the low bits of set B
    solSense <= 1'b1;
    rd(REG_MISC, 32'h700, 32'hfc0);
    // vote diagnostic latches, then clears on request once healthy
    apb(1'b1, REG_CFG, 32'h40);
    voteDis <= 1'b1;
    repeat (2) @(posedge mclk);
    voteDis <= 1'b0;
    rd(REG_DIAG, 32'h40000, 32'h40000);
    check(pDiag, 1'b1, "diag flag");
    diagReq <= 1'b1;
    @(posedge mclk);
    diagReq <= 1'b0;
    rd(REG_DIAG, 32'h0, 32'h40000);
    closeOut();
  end
endmodule : testbench
